/* File: design/exec_pkg.sv */
// Package with opcode patterns, phase encoding and reset values for the execution block.
// Assumes a 16-bit instruction word and an 8-bit data path.
package exec_pkg;

  // Opcode patterns, matched on the upper bits of the instruction word.
  localparam logic [7:0] OPC_MUL_LIT = 8'hBC;
  localparam logic [7:0] OPC_MOV_W_F = 8'h01;
  localparam logic [2:0] OPC_MOV_P_F = 3'h2;

  // Field positions within the instruction word.
  localparam int PERIPH_ADDR_LSB = 8;
  localparam int PERIPH_ADDR_W = 5;

  // Reset values.
  localparam logic [7:0] WORKING_RESET = 8'h00;
  localparam logic [7:0] PROD_RESET = 8'h00;

  // Four phases of one instruction cycle.
  typedef enum logic [1:0] {
    PH_DECODE,
    PH_READ,
    PH_PROCESS,
    PH_WRITE
  } phase_t;

  // Operation selected by decode.
  typedef enum logic [1:0] {
    OP_NONE,
    OP_MUL_LIT,
    OP_MOV_W_F,
    OP_MOV_P_F
  } op_t;

endpackage

/* File: design/lit_multiplier.sv */
// Unsigned 8 by 8 multiplier with a registered 16-bit result.
// Assumes synchronous operands held stable while load is high.
`timescale 1ns/1ps
module lit_multiplier #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic load,
  input wire logic [W-1:0] a,
  input wire logic [W-1:0] b,
  output logic [2*W-1:0] product
);

  // Full-width product, never truncated or saturated.
  always_ff @(posedge clk) begin
    if (rst) begin
      product <= '0;
    end else if (ce && load) begin
      product <= a * b;
    end
  end

endmodule

/* File: design/move_and_literal_multiply_exec.sv */
// Execution logic for the periph-to-file move, working-to-file move and literal multiply.
// Each accepted instruction walks decode, read, process and write phases, one clock each.
// Hold-value outputs keep their last result until the same kind of instruction runs again.
// Assumes an external register file answering reads combinationally in the same cycle.
// Assumes working_in stays stable from the take until the write phase has passed.
// Assumes instr and instr_valid are synchronous to clk and only looked at while idle.
// Assumes ce low freezes the whole block, so a stalled phase simply resumes later.
//
// Notes on behaviour
// - Opcode upper byte BC multiplies working register by the low-byte literal, unsigned.
// - The full 16-bit product is written to the product pair, never truncated.
// - Product high byte goes to high register, low byte to low register.
// - Literal multiply leaves working register and all status flags unchanged.
// - Opcode upper byte 01 copies working register to file register f.
// - Prefix 010 copies register at 5-bit address p into register at address f.
`timescale 1ns/1ps
module move_and_literal_multiply_exec #(
  parameter int DW = 8,
  parameter int AW = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic instr_valid,
  input wire logic [15:0] instr,
  input wire logic [DW-1:0] working_in,
  input wire logic [DW-1:0] rf_rdata,
  output logic [AW-1:0] rf_raddr,
  output logic rf_re,
  output logic [AW-1:0] rf_waddr,
  output logic [DW-1:0] rf_wdata,
  output logic rf_we,
  output logic [DW-1:0] product_high_byte,
  output logic [DW-1:0] product_low_byte,
  output logic prod_we,
  output logic status_we,
  output logic working_we,
  output logic busy,
  output logic done
);

  // Phase of the running instruction and its decoded operation.
  exec_pkg::phase_t phase_ff;
  exec_pkg::op_t op_ff;

  // Instruction word held for the whole cycle, since instr may change after the take.
  logic [15:0] instr_ff;

  // Source operand for the moves and the literal for the multiply.
  logic [DW-1:0] src_ff;
  logic [DW-1:0] lit_ff;

  // Registered product from the multiplier and its load strobe.
  logic [2*DW-1:0] product;
  logic mul_load;

  // Operation decoded from the offered word, used only at the take.
  exec_pkg::op_t nxt_op;

  // An instruction is accepted on an enabled edge in the idle decode phase.
  logic take;

  // Decode of the upper opcode bits.
  // The three-bit move prefix is tried last, as it is matched on the fewest bits.
  always_comb begin
    nxt_op = exec_pkg::OP_NONE;
    if (instr[15:8] == exec_pkg::OPC_MUL_LIT) begin
      nxt_op = exec_pkg::OP_MUL_LIT;
    end else if (instr[15:8] == exec_pkg::OPC_MOV_W_F) begin
      nxt_op = exec_pkg::OP_MOV_W_F;
    end else if (instr[15:13] == exec_pkg::OPC_MOV_P_F) begin
      nxt_op = exec_pkg::OP_MOV_P_F;
    end
  end

  // Phase sequencer: an accepted instruction walks all four phases.
  // ce low holds the phase, so an instruction stretched by a stall keeps its order.
  always_ff @(posedge clk) begin
    if (rst) begin
      phase_ff <= exec_pkg::PH_DECODE;
      busy <= 1'b0;
    end else if (ce) begin
      unique case (phase_ff)
        exec_pkg::PH_DECODE: begin
          if (busy || instr_valid) begin
            phase_ff <= exec_pkg::PH_READ;
            busy <= 1'b1;
          end
        end
        exec_pkg::PH_READ: phase_ff <= exec_pkg::PH_PROCESS;
        exec_pkg::PH_PROCESS: phase_ff <= exec_pkg::PH_WRITE;
        exec_pkg::PH_WRITE: begin
          phase_ff <= exec_pkg::PH_DECODE;
          busy <= 1'b0;
        end
      endcase
    end
  end

  // Take condition shared by the capture and read-strobe logic.
  assign take = ce && (phase_ff == exec_pkg::PH_DECODE) && !busy && instr_valid;

  // Capture the instruction and its operation in the decode phase.
  always_ff @(posedge clk) begin
    if (rst) begin
      instr_ff <= 16'h0000;
      op_ff <= exec_pkg::OP_NONE;
    end else if (take) begin
      instr_ff <= instr;
      op_ff <= nxt_op;
    end
  end

  // Read strobe and address: raised at the take so both stand during the read phase.
  always_ff @(posedge clk) begin
    if (rst) begin
      rf_re <= 1'b0;
      rf_raddr <= '0;
    end else if (ce) begin
      rf_re <= 1'b0;
      if (take && nxt_op == exec_pkg::OP_MOV_P_F) begin
        rf_re <= 1'b1;
        // The 5-bit peripheral address is zero-extended onto the read port.
        rf_raddr <= AW'(instr[exec_pkg::PERIPH_ADDR_LSB +: exec_pkg::PERIPH_ADDR_W]);
      end
    end
  end

  // Read phase: latch the source operand or the literal at its closing edge.
  // The register file answers combinationally, so rf_rdata is valid here.
  always_ff @(posedge clk) begin
    if (rst) begin
      src_ff <= exec_pkg::WORKING_RESET;
      lit_ff <= '0;
    end else if (ce && phase_ff == exec_pkg::PH_READ) begin
      unique case (op_ff)
        exec_pkg::OP_MOV_P_F: src_ff <= rf_rdata;
        exec_pkg::OP_MOV_W_F: src_ff <= working_in;
        exec_pkg::OP_MUL_LIT: lit_ff <= instr_ff[7:0];
        exec_pkg::OP_NONE: src_ff <= src_ff;
      endcase
    end
  end

  // Process phase starts the multiply.
  // The multiply is registered, so the product is ready for the write phase edge.
  assign mul_load = (phase_ff == exec_pkg::PH_PROCESS) && (op_ff == exec_pkg::OP_MUL_LIT);

  // Unsigned product of working register and literal, registered at the end of process.
  // Working register is read here, so the caller must hold it through the process phase.
  lit_multiplier #(.W(DW)) i_lit_multiplier (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .load(mul_load),
    .a(working_in),
    .b(lit_ff),
    .product(product)
  );

  // Product pair: both bytes load together from one product, in the write phase only.
  // A zero product is written like any other; no flag records it.
  always_ff @(posedge clk) begin
    if (rst) begin
      prod_we <= 1'b0;
      product_high_byte <= exec_pkg::PROD_RESET;
      product_low_byte <= exec_pkg::PROD_RESET;
    end else if (ce) begin
      prod_we <= 1'b0;
      if (phase_ff == exec_pkg::PH_WRITE && op_ff == exec_pkg::OP_MUL_LIT) begin
        product_high_byte <= product[2*DW-1:DW];
        product_low_byte <= product[DW-1:0];
        prod_we <= 1'b1;
      end
    end
  end

  // Register-file write for both moves; address f comes from the low opcode byte.
  // Unknown opcodes reach the write phase too but write nothing.
  always_ff @(posedge clk) begin
    if (rst) begin
      rf_we <= 1'b0;
      rf_waddr <= '0;
      rf_wdata <= '0;
    end else if (ce) begin
      rf_we <= 1'b0;
      if (phase_ff == exec_pkg::PH_WRITE) begin
        unique case (op_ff)
          exec_pkg::OP_MOV_W_F, exec_pkg::OP_MOV_P_F: begin
            rf_we <= 1'b1;
            rf_waddr <= AW'(instr_ff[7:0]);
            rf_wdata <= src_ff;
          end
          exec_pkg::OP_MUL_LIT, exec_pkg::OP_NONE: rf_we <= 1'b0;
        endcase
      end
    end
  end

  // Done pulses after every write phase, unknown opcodes included, so callers never hang.
  always_ff @(posedge clk) begin
    if (rst) begin
      done <= 1'b0;
    end else if (ce) begin
      done <= (phase_ff == exec_pkg::PH_WRITE);
    end
  end

  // None of these instructions write the working register or the flags.
  // The strobes exist so a core around this block can share write ports with other units.
  always_ff @(posedge clk) begin
    if (rst) begin
      status_we <= 1'b0;
      working_we <= 1'b0;
    end else if (ce) begin
      status_we <= 1'b0;
      working_we <= 1'b0;
    end
  end

endmodule

/* File: tb/exec_asserts.sv */
// Checker for the execution block.
// Assumes ce stays high while an instruction runs.
`timescale 1ns/1ps
module exec_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic instr_valid,
  input wire logic [15:0] instr,
  input wire logic [7:0] working_in,
  input wire logic [7:0] rf_raddr,
  input wire logic [7:0] rf_waddr,
  input wire logic [7:0] rf_wdata,
  input wire logic rf_we,
  input wire logic rf_re,
  input wire logic [7:0] product_high_byte,
  input wire logic [7:0] product_low_byte,
  input wire logic prod_we,
  input wire logic status_we,
  input wire logic working_we,
  input wire logic busy,
  input wire logic done
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // An instruction is taken when the block is idle and one is offered.
  wire tk = ce && !busy && instr_valid;
  AST_FLAGS: assert property (!status_we && !working_we)
    else $error("flag write seen");
  AST_CYCLE: assert property (tk |=> busy[*3] ##1 (done && !busy))
    else $error("cycle length wrong");
  AST_EARLY: assert property (tk |=> !(rf_we || prod_we) [*3])
    else $error("early write");
  AST_MUL: assert property (tk && instr[15:8] == 8'hBC |-> ##4 prod_we &&
    !rf_we &&
    {product_high_byte, product_low_byte} == $past(working_in, 4) * $past(instr[7:0], 4))
    else $error("product wrong");
  AST_MOVW: assert property (tk && instr[15:8] == 8'h01 |-> ##4 rf_we && !prod_we &&
    rf_waddr == $past(instr[7:0], 4) && rf_wdata == $past(working_in, 4))
    else $error("move of working register wrong");
  AST_MOVP: assert property (tk && instr[15:13] == 3'h2 |=>
    rf_re && rf_raddr == {3'h0, $past(instr[12:8])} ##3 rf_we && rf_waddr == $past(instr[7:0], 4))
    else $error("peripheral move wrong");
  AST_PAIR: assert property ($changed({product_high_byte, product_low_byte})
    |-> prod_we) else $error("product changed without strobe");
  AST_DONE: assert property ((rf_we || prod_we) |-> done)
    else $error("write outside write phase");
endmodule
bind move_and_literal_multiply_exec exec_asserts i_exec_asserts (
  .clk(clk),
  .rst(rst),
  .ce(ce),
  .instr_valid(instr_valid),
  .instr(instr),
  .working_in(working_in),
  .rf_raddr(rf_raddr),
  .rf_waddr(rf_waddr),
  .rf_wdata(rf_wdata),
  .rf_we(rf_we),
  .rf_re(rf_re),
  .product_high_byte(product_high_byte),
  .product_low_byte(product_low_byte),
  .prod_we(prod_we),
  .status_we(status_we),
  .working_we(working_we),
  .busy(busy),
  .done(done)
);

/* File: tb/move_and_literal_multiply_exec_tb_top.sv */
// Self-checking bench for the execution block.
// Assumes the checker is bound and the register file reads combinationally.
`timescale 1ns/1ps
module move_and_literal_multiply_exec_tb_top;
  logic clk = 0, rst = 1, ce = 1, instr_valid = 0;
  logic [15:0] instr = 16'h0000;
  logic [7:0] working_in = 8'h00;
  logic [7:0] rf_raddr, rf_waddr, rf_wdata, product_high_byte, product_low_byte;
  logic rf_re, rf_we, prod_we, status_we, working_we, busy, done;
  logic [17:0] exp_q[$];
  logic [17:0] seen, want;
  int n_errors = 0, n_checks = 0, seed = 32'h24D4;
  // Register file returns a fixed function of the address.
  wire [7:0] rf_rdata = rf_raddr ^ 8'hA5;
  always #50 clk = ~clk;
  move_and_literal_multiply_exec i_move_and_literal_multiply_exec (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .instr_valid(instr_valid),
    .instr(instr),
    .working_in(working_in),
    .rf_rdata(rf_rdata),
    .rf_raddr(rf_raddr),
    .rf_re(rf_re),
    .rf_waddr(rf_waddr),
    .rf_wdata(rf_wdata),
    .rf_we(rf_we),
    .product_high_byte(product_high_byte),
    .product_low_byte(product_low_byte),
    .prod_we(prod_we),
    .status_we(status_we),
    .working_we(working_we),
    .busy(busy),
    .done(done)
  );
  // Offers one instruction, notes its result and returns at the edge that opens its write phase.
  task automatic issue(input logic [15:0] i, input logic [7:0] w);
    @(posedge clk);
    instr <= i;
    working_in <= w;
    instr_valid <= 1'b1;
    if (i[15:8] == 8'hBC) exp_q.push_back({2'b10, 16'(w) * 16'(i[7:0])});
    else if (i[15:8] == 8'h01) exp_q.push_back({2'b01, i[7:0], w});
    else if (i[15:13] == 3'h2) exp_q.push_back({2'b01, i[7:0], {3'h0, i[12:8]} ^ 8'hA5});
    else exp_q.push_back(18'h0);
    @(posedge clk);
    instr_valid <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  // Compares each finished instruction with the oldest note.
  always @(negedge clk) begin
    if (done === 1'b1) begin
      seen = prod_we ? {2'b10, product_high_byte, product_low_byte} :
        {1'b0, rf_we, rf_we ? {rf_waddr, rf_wdata} : 16'h0};
      want = exp_q.size() > 0 ? exp_q.pop_front() : 18'h3FFFF;
      n_checks++;
      if (seen !== want) begin
        n_errors++;
        $display("wrong value result expected %h seen %h", want, seen);
      end
    end
  end
  // Directed corner products, then a random mix of all opcodes.
  initial begin
    logic [31:0] r;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    issue(16'hBCC4, 8'hE2);
    issue(16'hBC00, 8'hFF);
    issue(16'hBCFF, 8'hFF);
    // Offer a multiply while ce is low: a frozen block must not take it.
    repeat (3) @(posedge clk);
    ce <= 1'b0;
    instr <= 16'hBC55;
    instr_valid <= 1'b1;
    repeat (3) @(posedge clk);
    instr_valid <= 1'b0;
    ce <= 1'b1;
    for (int n = 0; n < 60; n++) begin
      r = $random(seed);
      case (r[1:0])
        2'd0: issue({8'hBC, r[15:8]}, r[23:16]);
        2'd1: issue({8'h01, r[15:8]}, r[23:16]);
        2'd2: issue({3'h2, r[12:0]}, r[23:16]);
        default: issue({8'hFF, r[15:8]}, r[23:16]);
      endcase
    end
    for (int t = 0; t < 20 && exp_q.size() > 0; t++) @(posedge clk);
    if (exp_q.size() > 0) n_errors++;
    tally_and_finish();
  end
  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
endmodule
